// [hw/sfe_pkg.sv]
// Shared constants for the serial flash erase control block
package sfe_pkg;
    // ==========================================
    // Instruction codes
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
    // ==========================================
    // Array geometry
    localparam int ADDR_W = 17;
    localparam int NBLK = 4;
    localparam int BLK_LSB = 15;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // ==========================================
    // Frame layout: opcode byte alone, or opcode byte plus three address bytes
    localparam logic [2:0] BYTES_CMD = 3'h1;
    localparam logic [2:0] BYTES_ADDR_CMD = 3'h4;
    // ==========================================
    // Status byte fields
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // ==========================================
    // Timing
    localparam longint unsigned CLK_HZ = 200_000_000;
    localparam longint unsigned CHIP_ERASE_S = 8;
    localparam longint unsigned BLOCK_ERASE_US = 1000;
    localparam longint unsigned CHIP_ERASE_CYC = CHIP_ERASE_S * CLK_HZ;
    localparam longint unsigned BLOCK_ERASE_CYC = (BLOCK_ERASE_US * CLK_HZ) / 64'd1_000_000;
endpackage

// [hw/sfe_erase_if.sv]
// Request and progress signals between command decoder and erase engine
`timescale 1ns/1ps
interface sfe_erase_if;
    import sfe_pkg::*;
    logic start;
    logic chip;
    logic [NBLK-1:0] mask;
    logic busy;
    logic done;
    logic we;
    logic [ADDR_W-1:0] addr;
    modport ctl (output start, output chip, output mask, input busy, input done, input we, input addr);
    modport eng (input start, input chip, input mask, output busy, output done, output we, output addr);
endinterface

// [hw/sfe_erase_eng.sv]
// Self-timed erase engine: walks the array writing erased bytes to selected blocks
`timescale 1ns/1ps
module sfe_erase_eng
    import sfe_pkg::*;
#(
    parameter logic [31:0] BLK_CYC = 32'(BLOCK_ERASE_CYC),
    parameter logic [31:0] CHIP_CYC = 32'(CHIP_ERASE_CYC)
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request port
    sfe_erase_if.eng ers
);
    logic busy_r;
    logic done_r;
    logic walk_r;
    logic we_r;
    logic [ADDR_W-1:0] pos_r;
    logic [ADDR_W-1:0] addr_r;
    logic [NBLK-1:0] mask_r;
    logic [31:0] tmr_r;
    logic finish;

    assign finish = busy_r && !walk_r && tmr_r == 32'h0;
    assign ers.busy = busy_r;
    assign ers.done = done_r;
    assign ers.we = we_r;
    assign ers.addr = addr_r;

    // ==========================================
    // Busy and internal timer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            tmr_r <= 32'h0;
            mask_r <= '0;
        end
        else
        begin
            done_r <= finish;
            if (ers.start && !busy_r)
            begin
                busy_r <= 1'b1;
                mask_r <= ers.mask;
                tmr_r <= ers.chip ? CHIP_CYC : BLK_CYC;
            end
            else if (finish)
                busy_r <= 1'b0;
            else if (tmr_r != 32'h0)
                tmr_r <= tmr_r - 32'h1;
        end
    end

    // ==========================================
    // Address walk, one byte per cycle through selected blocks; an unselected block costs one cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            walk_r <= 1'b0;
            pos_r <= '0;
            we_r <= 1'b0;
            addr_r <= '0;
        end
        else
        begin
            we_r <= walk_r && mask_r[pos_r[ADDR_W-1:BLK_LSB]];
            addr_r <= pos_r;
            if (ers.start && !busy_r)
            begin
                walk_r <= 1'b1;
                pos_r <= '0;
            end
            else if (walk_r)
            begin
                if (mask_r[pos_r[ADDR_W-1:BLK_LSB]])
                    pos_r <= pos_r + 1'b1;
                else
                    pos_r <= {pos_r[ADDR_W-1:BLK_LSB] + 2'h1, {BLK_LSB{1'b0}}};
                if (&pos_r || (&pos_r[ADDR_W-1:BLK_LSB] && !mask_r[pos_r[ADDR_W-1:BLK_LSB]]))
                    walk_r <= 1'b0;
            end
        end
    end

    // ==========================================
    // Checks
    property p_start_busy;
        @(posedge clk) disable iff (!rst_n) ers.start && !busy_r |=> busy_r [*2];
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("erase did not stay busy");

    property p_done_idle;
        @(posedge clk) disable iff (!rst_n) done_r |-> !busy_r && $past(busy_r) ##1 !done_r;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done not a single pulse at end of busy");

    property p_we_mask;
        @(posedge clk) disable iff (!rst_n) we_r |-> mask_r[addr_r[ADDR_W-1:BLK_LSB]] && busy_r;
    endproperty
    a_we_mask: assert property (p_we_mask) else $error("write outside selected blocks");

    property p_chip_time;
        @(posedge clk) disable iff (!rst_n) ers.start && ers.chip && !busy_r |=> tmr_r == CHIP_CYC;
    endproperty
    a_chip_time: assert property (p_chip_time) else $error("chip erase timer not loaded");

    c_chip: cover property (@(posedge clk) disable iff (!rst_n) ers.start && ers.chip && !busy_r);
    c_done: cover property (@(posedge clk) disable iff (!rst_n) done_r);
endmodule // sfe_erase_eng

// [hw/sfe_top.sv]
// Serial flash erase control: SPI instruction decoder, write latch and status
`timescale 1ns/1ps
module sfe_top
    import sfe_pkg::*;
#(
    parameter logic [31:0] BLK_CYC = 32'(BLOCK_ERASE_CYC),
    parameter logic [31:0] CHIP_CYC = 32'(CHIP_ERASE_CYC)
)(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // SPI link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // Lock-out per block
    input wire logic [NBLK-1:0] block_lock,
    // Array write port
    output logic arr_we,
    output logic [ADDR_W-1:0] arr_addr,
    output logic [7:0] arr_wdata,
    output logic erase_busy
);
    logic rst_q1;
    logic rst_n;
    logic [2:0] cs_p;
    logic [2:0] sck_p;
    logic [1:0] si_p;
    logic [NBLK-1:0] lock_q1;
    logic [NBLK-1:0] lock_s;
    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    logic [7:0] sh_r;
    logic [2:0] bcnt_r;
    logic [2:0] nbyte_r;
    logic [7:0] opc_r;
    logic [23:0] addr_r;
    logic stat_mode_r;
    logic [7:0] out_sh_r;
    logic so_r;
    logic wel_r;
    logic start_r;
    logic chip_r;
    logic [NBLK-1:0] mask_r;
    logic [7:0] in_byte;
    logic [7:0] status;
    logic [NBLK-1:0] blk_sel;
    logic exec_blk;
    logic exec_chip;
    logic exec_set_write_latch_cmd;

    sfe_erase_if ers ();

    sfe_erase_eng #(.BLK_CYC(BLK_CYC), .CHIP_CYC(CHIP_CYC)) u_eng (
        .clk(clk),
        .rst_n(rst_n),
        .ers(ers.eng)
    );

    // ==========================================
    // Reset release and pin synchronisers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_p <= 3'h7;
            sck_p <= 3'h0;
            si_p <= 2'h0;
            lock_q1 <= '1;
            lock_s <= '1;
        end
        else
        begin
            cs_p <= {cs_p[1:0], cs_n};
            sck_p <= {sck_p[1:0], sck};
            si_p <= {si_p[0], si};
            lock_q1 <= block_lock;
            lock_s <= lock_q1;
        end
    end

    assign sck_rise = sck_p[1] && !sck_p[2] && !cs_p[1];
    assign sck_fall = !sck_p[1] && sck_p[2] && !cs_p[1];
    assign frame_end = cs_p[1] && !cs_p[2];
    assign in_byte = {sh_r[6:0], si_p[1]};
    assign status = STATUS_RST | {6'h0, wel_r, ers.busy};

    // ==========================================
    // Byte assembly, mode 0: sample on rising clock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_r <= 8'h00;
            bcnt_r <= 3'h0;
            nbyte_r <= 3'h0;
            opc_r <= 8'h00;
            addr_r <= 24'h0;
            stat_mode_r <= 1'b0;
        end
        else if (cs_p[1])
        begin
            bcnt_r <= 3'h0;
            nbyte_r <= 3'h0;
            stat_mode_r <= 1'b0;
        end
        else if (sck_rise)
        begin
            sh_r <= in_byte;
            bcnt_r <= bcnt_r + 3'h1;
            if (bcnt_r == 3'h7)
            begin
                if (nbyte_r != BYTES_ADDR_CMD + 3'h1)
                    nbyte_r <= nbyte_r + 3'h1;
                if (nbyte_r == 3'h0)
                begin
                    opc_r <= in_byte;
                    stat_mode_r <= in_byte == OP_READ_STATUS;
                end
                else
                    addr_r <= {addr_r[15:0], in_byte};
            end
        end
    end

    // ==========================================
    // Status output, shifted on falling clock, refreshed each byte
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_sh_r <= 8'h00;
            so_r <= 1'b0;
        end
        else if (sck_fall && stat_mode_r)
        begin
            if (bcnt_r == 3'h0)
            begin
                so_r <= status[7];
                out_sh_r <= {status[6:0], 1'b0};
            end
            else
            begin
                so_r <= out_sh_r[7];
                out_sh_r <= {out_sh_r[6:0], 1'b0};
            end
        end
    end

    assign so = so_r;
    assign so_oe = !cs_p[1];

    // ==========================================
    // Instruction execution at the end of the frame
    assign blk_sel = NBLK'(1) << addr_r[BLK_LSB +: 2];
    assign exec_set_write_latch_cmd = frame_end && bcnt_r == 3'h0 && !ers.busy && opc_r == OP_SET_WRITE_LATCH
        && nbyte_r == BYTES_CMD;
    assign exec_blk = frame_end && bcnt_r == 3'h0 && !ers.busy && wel_r && opc_r == OP_BLOCK_ERASE
        && nbyte_r == BYTES_ADDR_CMD && (blk_sel & lock_s) == '0;
    assign exec_chip = frame_end && bcnt_r == 3'h0 && !ers.busy && wel_r && opc_r == OP_CHIP_ERASE
        && nbyte_r == BYTES_CMD;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wel_r <= 1'b0;
        else if (exec_set_write_latch_cmd)
            wel_r <= 1'b1;
        else if (ers.done)
            wel_r <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_r <= 1'b0;
            chip_r <= 1'b0;
            mask_r <= '0;
        end
        else
        begin
            start_r <= exec_blk || exec_chip;
            if (exec_blk)
            begin
                chip_r <= 1'b0;
                mask_r <= blk_sel;
            end
            else if (exec_chip)
            begin
                chip_r <= 1'b1;
                mask_r <= ~lock_s;
            end
        end
    end

    assign ers.start = start_r;
    assign ers.chip = chip_r;
    assign ers.mask = mask_r;
    assign arr_we = ers.we;
    assign arr_addr = ers.addr;
    assign arr_wdata = ERASED_BYTE;
    assign erase_busy = ers.busy;

    // ==========================================
    // Checks
    property p_busy_ignore;
        @(posedge clk) disable iff (!rst_n) ers.busy && frame_end |=> $stable(wel_r) && !start_r;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("instruction acted on while busy");

    property p_wel_clear;
        @(posedge clk) disable iff (!rst_n) ers.done |=> !wel_r;
    endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("write latch kept after erase");

    property p_need_wel;
        @(posedge clk) disable iff (!rst_n) start_r |-> $past(wel_r);
    endproperty
    a_need_wel: assert property (p_need_wel) else $error("erase started without write latch");

    property p_lock;
        @(posedge clk) disable iff (!rst_n) start_r |-> (mask_r & $past(lock_s)) == '0;
    endproperty
    a_lock: assert property (p_lock) else $error("locked block selected for erase");

    property p_blk_addr;
        @(posedge clk) disable iff (!rst_n) start_r && !chip_r |-> mask_r == (NBLK'(1) << addr_r[BLK_LSB +: 2]);
    endproperty
    a_blk_addr: assert property (p_blk_addr) else $error("wrong block derived from address");

    property p_busy_follows;
        @(posedge clk) disable iff (!rst_n) start_r |=> erase_busy ##1 erase_busy;
    endproperty
    a_busy_follows: assert property (p_busy_follows) else $error("busy did not follow erase start");

    c_blk: cover property (@(posedge clk) disable iff (!rst_n) exec_blk);
    c_poll: cover property (@(posedge clk) disable iff (!rst_n) ers.busy && stat_mode_r && sck_fall);
    c_set_write_latch_cmd: cover property (@(posedge clk) disable iff (!rst_n) exec_set_write_latch_cmd);
endmodule // sfe_top

// [testbench/sfe_spi_host.sv]
// SPI host model issuing framed mode 0 instructions
`timescale 1ns/1ps
module sfe_spi_host
(
    // Clock
    input wire logic clk,
    // SPI link
    input wire logic so,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si
);
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // ==========================================
    // Frame: nbits taken MSB first from tx; sck idles low between frames
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge clk) #1 cs_n = 1'b0;
        repeat (6) @(posedge clk);
        for (int i = 0; i < nbits; i++)
        begin
            #1 si = tx[31 - i];
            repeat (12) @(posedge clk);
            #1 sck = 1'b1;
            rx = {rx[6:0], so & so_oe};
            repeat (13) @(posedge clk);
            #1 sck = 1'b0;
        end
        repeat (12) @(posedge clk);
        // Released data line shows no stale value
        #1 si = ~si;
        cs_n = 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule // sfe_spi_host

// [testbench/sfe_top_tb.sv]
// Self-checking bench for the serial flash erase control block
`timescale 1ns/1ps
module sfe_top_tb;
    import sfe_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [NBLK-1:0] block_lock = '0;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic arr_we;
    logic [ADDR_W-1:0] arr_addr;
    logic [7:0] arr_wdata;
    logic erase_busy;
    logic [7:0] st;
    int errors = 0;
    int cmp_count = 0;
    int bad_data = 0;
    int cyc;
    int busy_cyc = 0;
    int wr_cnt [NBLK];

    always #2.5 clk = ~clk;

    sfe_top #(.BLK_CYC(32'd10), .CHIP_CYC(32'd20)) u_dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
        .si(si), .so(so), .so_oe(so_oe), .block_lock(block_lock), .arr_we(arr_we), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata), .erase_busy(erase_busy));
    sfe_spi_host u_host (.clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));

    // ==========================================
    // Array model: count writes per block
    always @(posedge clk)
    begin
        if (erase_busy === 1'b1)
            busy_cyc++;
        if (arr_we === 1'b1)
        begin
            wr_cnt[arr_addr[ADDR_W-1:BLK_LSB]]++;
            if (arr_wdata !== ERASED_BYTE)
                bad_data++;
        end
    end

    // ==========================================
    // Helpers
    task automatic complete_run;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_int(input int got, input int exp, input string what);
        cmp_count++;
        if (got != exp)
        begin
            errors++;
            $display("Error %0t: %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        u_host.xfer({op, 24'h000000}, 8, st);
    endtask
    task automatic status;
        u_host.xfer({OP_READ_STATUS, 24'h000000}, 16, st);
    endtask
    task automatic ers_blk(input logic [23:0] a);
        u_host.xfer({OP_BLOCK_ERASE, a}, 32, st);
    endtask
    task automatic chk_blocks(input logic [NBLK-1:0] sel);
        for (int b = 0; b < NBLK; b++)
        begin
            chk_int(wr_cnt[b], sel[b] ? (1 << BLK_LSB) : 0, "block writes");
            wr_cnt[b] = 0;
        end
        busy_cyc = 0;
        chk_int(bad_data, 0, "written data");
    endtask
    task automatic wait_idle;
        cyc = 0;
        while (erase_busy !== 1'b0)
        begin
            @(posedge clk) #1;
            cyc++;
            if (cyc > 200000)
            begin
                errors++;
                $display("Error %0t: erase never finished", $time);
                complete_run();
            end
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic s_no_latch;
        ers_blk(24'h000000);
        cmd(OP_CHIP_ERASE);
        status();
        chk_byte(st, 8'h00, "status no latch");
        chk_blocks(4'h0);
    endtask
    task automatic s_locked;
        @(posedge clk) #1 block_lock = 4'h2;
        cmd(OP_SET_WRITE_LATCH);
        ers_blk(24'h00abcd);
        status();
        chk_byte(st, 8'h02, "status locked");
        chk_blocks(4'h0);
    endtask
    task automatic s_block;
        @(posedge clk) #1 block_lock = 4'h8;
        ers_blk(24'h012345);
        status();
        chk_byte(st, 8'h03, "status block busy");
        cmd(OP_SET_WRITE_LATCH);
        cmd(OP_CHIP_ERASE);
        wait_idle();
        chk_int(int'(busy_cyc >= (1 << BLK_LSB)), 1, "block busy length");
        chk_blocks(4'h4);
        status();
        chk_byte(st, 8'h00, "status block done");
    endtask
    task automatic s_chip;
        @(posedge clk) #1 block_lock = 4'h7;
        cmd(OP_SET_WRITE_LATCH);
        cmd(OP_CHIP_ERASE);
        status();
        chk_byte(st, 8'h03, "status chip busy");
        wait_idle();
        chk_int(int'(busy_cyc >= (1 << BLK_LSB)), 1, "chip busy length");
        chk_blocks(4'h8);
        status();
        chk_byte(st, 8'h00, "status chip done");
    endtask

    initial
    begin
        for (int b = 0; b < NBLK; b++)
            wr_cnt[b] = 0;
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (8) @(posedge clk);
        s_no_latch();
        s_locked();
        s_block();
        s_chip();
        complete_run();
    end
endmodule // sfe_top_tb
